//--- bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model(
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic        op_wr_in,
    input  wire logic        word_in,
    input  wire logic [15:0] a_in,
    input  wire logic [15:0] d_in,
    input  wire logic [3:0]  slow_in,
    input  wire logic        xack_in,
    input  wire logic [15:0] bus_rd_in,
    output var  logic [15:0] addr_out = 16'h0000,
    output var  logic        bhe_out = 1'b0,
    output var  logic        rd_out = 1'b0,
    output var  logic        wr_out = 1'b0,
    output var  logic [15:0] data_out = 16'h0000,
    output var  logic        done_out = 1'b0,
    output var  logic        ack_out = 1'b0,
    output var  logic [15:0] rdata_out = 16'h0000
);
    int n;
    // ==========
    // one command, held until ack or give-up
    always begin
        @(posedge clk_in);
        if (go_in) begin
            addr_out <= a_in;
            bhe_out  <= word_in;
            data_out <= d_in;
            rd_out   <= !op_wr_in;
            wr_out   <= op_wr_in;
            n = 0;
            do begin @(posedge clk_in); n++; end while (!xack_in && n < 90);
            ack_out   <= xack_in;
            rdata_out <= bus_rd_in;
            repeat (slow_in) @(posedge clk_in);
            rd_out   <= 1'b0;
            wr_out   <= 1'b0;
            data_out <= ~d_in; // released lines must not keep old value
            done_out <= 1'b1;
            @(posedge clk_in);
            done_out <= 1'b0;
        end
    end
endmodule // bus_master_model
`default_nettype wire

//--- bus_slave_static_ram_control.v
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_consts.vh"
module bus_slave_static_ram_control #(
    parameter ONESHOT_LEN = `ONESHOT_CYCLES
) (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    input  wire [15:0] addr_in,
    input  wire        byte_high_en_in,
    input  wire        read_cmd_in,
    input  wire        write_cmd_in,
    input  wire        inhibit_in,
    input  wire        power_fail_in,
    input  wire        strap_upper_half_in,
    input  wire [2:0]  strap_block_in,
    input  wire        strap_aack_en_in,
    input  wire [15:0] bus_data_in,
    input  wire [7:0]  ram_upper_rd_in,
    input  wire [7:0]  ram_lower_rd_in,
    output reg  [15:0] bus_data_out,
    output reg         bus_data_oe_n_out,
    output reg         xack_out,
    output reg         aack_out,
    output reg         board_select_out,
    output reg         read_direction_n_out,
    output reg         byte_swap_enable_out,
    output reg  [7:0]  upper_chip_pair_selects_out,
    output reg  [7:0]  lower_chip_pair_selects_out,
    output reg  [7:0]  ram_byte_addr_out,
    output reg  [7:0]  ram_upper_wr_out,
    output reg  [7:0]  ram_lower_wr_out,
    output reg         write_strobe_a_n_out,
    output reg         write_strobe_b_n_out,
    output reg         secondary_chip_enable_out,
    output reg  [7:0]  ram_block_n_out,
    output reg  [3:0]  seq_slot_out
);
    localparam ST_IDLE  = 4'b0001;
    localparam ST_RUN   = 4'b0010;
    localparam ST_DONE  = 4'b0100;
    localparam ST_CLEAR = 4'b1000;
    function [7:0] one_hot8;
        input [2:0] sel;
        begin
            one_hot8 = 8'h01 << sel;
        end
    endfunction
    // ==========================================================
    // address decode
    // ==========================================================
    wire       top_ok   = (addr_in[15] == strap_upper_half_in);            // RULE2
    wire [7:0] block_n  = top_ok ? ~one_hot8(addr_in[14:12]) : 8'hFF;      // RULE3
    wire       selected = top_ok && (addr_in[14:12] == strap_block_in);    // RULE1 RULE3
    wire       odd_byte = addr_in[0] && !byte_high_en_in;                  // RULE6 RULE9
    wire       up_en    = !addr_in[0];                                     // RULE7 RULE10
    wire       lo_en    = addr_in[0] || byte_high_en_in;                   // RULE5 RULE10
    wire       cmd      = read_cmd_in || write_cmd_in;
    // ==========================================================
    // sequencer and latches
    // ==========================================================
    reg [3:0]  state_reg;
    reg [3:0]  state_next;
    reg [15:0] shift_reg;
    reg        tick_reg;
    reg        start_reg;
    reg        wl1_reg;
    reg        wl2_reg;
    reg        inh_reg;
    reg        is_write_reg;
    reg [7:0]  os_cnt_reg;
    // ones fill from bit 0, so the topmost one marks the current slot
    wire [15:0] slot = shift_reg & ~(shift_reg >> 1);
    // 20 MHz step from a 40 MHz clock
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= ~tick_reg;                                         // RULE14
        end
    end
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  if (selected && cmd && !power_fail_in) state_next = ST_RUN; // RULE4 RULE15
            ST_RUN:   if (!cmd) state_next = ST_DONE;                      // RULE20
            ST_DONE:  state_next = ST_CLEAR;
            ST_CLEAR: if (os_cnt_reg == 8'h00) state_next = ST_IDLE;       // RULE25
            default:  state_next = ST_IDLE;
        endcase
    end
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg    <= ST_IDLE;
            shift_reg    <= 16'h0000;
            start_reg    <= 1'b0;
            wl1_reg      <= 1'b0;
            wl2_reg      <= 1'b0;
            inh_reg      <= 1'b0;
            is_write_reg <= 1'b0;
            os_cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && state_next == ST_RUN) begin
                start_reg    <= 1'b1;                                      // RULE15
                is_write_reg <= write_cmd_in;
                inh_reg      <= inhibit_in;                                // RULE22
            end
            if (state_reg == ST_RUN && inhibit_in) begin
                inh_reg <= 1'b1;
            end
            if (start_reg && tick_reg) begin
                shift_reg <= {shift_reg[14:0], 1'b1};                      // RULE14 RULE15
            end
            if (is_write_reg && start_reg && tick_reg) begin
                if (shift_reg[`SLOT_WL1_SET - 1]) wl1_reg <= 1'b1;         // RULE16
                if (shift_reg[`SLOT_WL2_SET - 1]) wl2_reg <= 1'b1;         // RULE16
                if (shift_reg[`SLOT_WL1_CLR - 1]) wl1_reg <= 1'b0;         // RULE17
            end
            if (state_reg == ST_DONE) begin
                os_cnt_reg <= ONESHOT_LEN[7:0];                            // RULE24
            end else if (state_reg == ST_CLEAR) begin
                shift_reg  <= 16'h0000;                                    // RULE20 RULE24
                start_reg  <= 1'b0;
                wl1_reg    <= 1'b0;
                wl2_reg    <= 1'b0;
                inh_reg    <= 1'b0;
                if (os_cnt_reg != 8'h00) os_cnt_reg <= os_cnt_reg - 8'h01;
            end
            if (power_fail_in) begin
                wl1_reg <= 1'b0;                                           // RULE21
                wl2_reg <= 1'b0;
            end
        end
    end
    // ==========================================================
    // registered outputs
    // ==========================================================
    // inhibit latched at start keeps the buffers and both acknowledges off for the whole cycle
    wire blocked = inh_reg || inhibit_in;                                  // RULE22
    wire active  = selected && (start_reg || cmd);
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_data_out                <= 16'h0000;
            bus_data_oe_n_out           <= 1'b1;
            xack_out                    <= 1'b0;
            aack_out                    <= 1'b0;
            board_select_out            <= 1'b0;
            read_direction_n_out        <= 1'b1;
            byte_swap_enable_out        <= 1'b0;
            upper_chip_pair_selects_out <= 8'h00;
            lower_chip_pair_selects_out <= 8'h00;
            ram_byte_addr_out           <= 8'h00;
            ram_upper_wr_out            <= 8'h00;
            ram_lower_wr_out            <= 8'h00;
            write_strobe_a_n_out        <= 1'b1;
            write_strobe_b_n_out        <= 1'b1;
            secondary_chip_enable_out   <= 1'b0;
            ram_block_n_out             <= 8'hFF;
            seq_slot_out                <= 4'h0;
        end else begin
            board_select_out     <= selected;
            ram_block_n_out      <= block_n;                               // RULE3
            read_direction_n_out <= !(selected && read_cmd_in);            // RULE13
            byte_swap_enable_out <= selected && odd_byte;                  // RULE6 RULE9
            upper_chip_pair_selects_out <= (selected && up_en) ?
                one_hot8(addr_in[11:9]) : 8'h00;                           // RULE7
            lower_chip_pair_selects_out <= (selected && lo_en) ?
                one_hot8(addr_in[11:9]) : 8'h00;                           // RULE9
            ram_byte_addr_out    <= addr_in[8:1];                          // RULE8
            ram_upper_wr_out     <= bus_data_in[7:0];
            ram_lower_wr_out     <= odd_byte ? bus_data_in[7:0] : bus_data_in[15:8]; // RULE9
            if (odd_byte) begin
                bus_data_out <= {8'h00, ram_lower_rd_in};                  // RULE11
            end else begin
                bus_data_out <= {ram_lower_rd_in, ram_upper_rd_in};        // RULE11
            end
            bus_data_oe_n_out    <= !(active && read_cmd_in && !blocked);  // RULE12 RULE22
            write_strobe_a_n_out <= !(wl1_reg && wl2_reg);                 // RULE16 RULE17
            write_strobe_b_n_out <= !(wl1_reg && wl2_reg);
            xack_out  <= start_reg && shift_reg[`SLOT_XACK - 1] && !blocked;      // RULE18
            aack_out  <= strap_aack_en_in && start_reg &&
                         shift_reg[`SLOT_AACK - 1] && !blocked;            // RULE23
            secondary_chip_enable_out <= !power_fail_in;                   // RULE21
            seq_slot_out <= shift_reg[15] ? 4'hF :
                            (shift_reg == 16'h0000) ? 4'h0 : slot_index(slot);
        end
    end
    function [3:0] slot_index;
        input [15:0] oh;
        integer i;
        begin
            slot_index = 4'h0;
            for (i = 0; i < 16; i = i + 1) begin
                if (oh[i]) slot_index = i[3:0] + 4'h1;
            end
        end
    endfunction
endmodule // bus_slave_static_ram_control
`default_nettype wire

//--- ram_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ram_ctrl_sva(
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic [15:0] addr_in,
    input wire logic        read_cmd_in,
    input wire logic        write_cmd_in,
    input wire logic        inhibit_in,
    input wire logic        power_fail_in,
    input wire logic        strap_aack_en_in,
    input wire logic        strap_upper_half_in,
    input wire logic [3:0]  seq_slot_out,
    input wire logic        bus_data_oe_n_out,
    input wire logic        xack_out,
    input wire logic        aack_out,
    input wire logic        board_select_out,
    input wire logic        read_direction_n_out,
    input wire logic        write_strobe_a_n_out,
    input wire logic        write_strobe_b_n_out,
    input wire logic        secondary_chip_enable_out,
    input wire logic [7:0]  ram_block_n_out
);
    // ==========
    // properties
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_block_decode: assert property ($stable(addr_in) && (addr_in[15] == strap_upper_half_in) |=>
        ram_block_n_out == ~(8'h01 << $past(addr_in[14:12]))) else $error("block decode wrong");
    a_ack_selected: assert property (xack_out |-> board_select_out) else $error("ack unselected");
    a_strobe_pair: assert property (write_strobe_a_n_out == write_strobe_b_n_out)
        else $error("strobes differ");
    a_strobe_write: assert property (!write_strobe_a_n_out |-> read_direction_n_out && !xack_out)
        else $error("strobe overlaps ack or read");
    a_oe_read: assert property (!bus_data_oe_n_out |-> !read_direction_n_out)
        else $error("driving bus outside read");
    a_ack_holds: assert property (xack_out && (read_cmd_in || write_cmd_in) && !inhibit_in
        |=> xack_out) else $error("ack dropped early");
    a_inhibit_quiet: assert property (inhibit_in |=> bus_data_oe_n_out && !xack_out && !aack_out)
        else $error("inhibit ignored");
    a_aack_first: assert property ($rose(xack_out) && strap_aack_en_in |-> aack_out)
        else $error("advance ack missing");
    a_aack_strap: assert property ((!strap_aack_en_in) [*2] |-> !aack_out)
        else $error("advance ack without strap");
    a_power_block: assert property (power_fail_in |=> !secondary_chip_enable_out)
        else $error("ram enabled in power loss");
    a_ack_slot: assert property ($rose(xack_out) |-> seq_slot_out == 4'hE)
        else $error("ack outside its slot");
    c_read: cover property ($rose(xack_out) && !read_direction_n_out);
    c_write: cover property ($fell(write_strobe_a_n_out));
    c_inhibit: cover property (inhibit_in && read_cmd_in);
endmodule // ram_ctrl_sva
`default_nettype wire

//--- sram_ctrl_consts.vh
// How it works
// RULE1: top four address bits select the board
// RULE2: strap sets polarity of topmost address bit
// RULE3: three bits decode eight blocks, strap picks one
// RULE4: commands answered only while board selected
// RULE5: two byte arrays of 2K each
// RULE6: low address bit and high enable pick array
// RULE7: even byte enables upper chip decoder
// RULE8: address bits 1 to 8 select byte
// RULE9: odd byte enables lower decoder through swap
// RULE10: master asserts high enable, even address, words
// RULE11: byte reads land on data lines 0 to 7
// RULE12: buffers drive on read, isolate when unselected
// RULE13: read direction follows command while selected
// RULE14: sixteen slot sequencer at 20 MHz
// RULE15: command sets start latch, ones shift in
// RULE16: write latches set at T1 and T4
// RULE17: write strobes end at T13
// RULE18: transfer acknowledge at T14
// RULE19: master drops command after acknowledge
// RULE20: command removal fires one-shot clearing all
// RULE21: power loss drives secondary chip enable inactive
// RULE22: inhibit isolates buffers and both acknowledges
// RULE23: strap enables advance acknowledge 500 ns early
// RULE24: one-shot is counter, clears sequencer fully
// RULE25: no new cycle until clear finished
`ifndef SRAM_CTRL_CONSTS_VH
`define SRAM_CTRL_CONSTS_VH
`define SEQ_SLOTS         16
`define SLOT_WL1_SET      1
`define SLOT_WL2_SET      4
`define SLOT_WL1_CLR      13
`define SLOT_XACK         14
`define AACK_LEAD_NS      500
`define SEQ_CLK_HZ        20000000
`define SYS_CLK_HZ        40000000
`define CLKS_PER_SLOT     (`SYS_CLK_HZ / `SEQ_CLK_HZ)
`define SEQ_PERIOD_NS     (1000000000 / `SEQ_CLK_HZ)
`define SLOT_AACK         (`SLOT_XACK - (`AACK_LEAD_NS / `SEQ_PERIOD_NS))
`define ONESHOT_CYCLES    4
`define ADDR_W            16
`define BYTE_ADDR_W       8
`define CHIP_SEL_LSB      9
`define BLOCK_LSB         12
`endif

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_in = 0, sys_rst_in = 1, go = 0, op = 0, wd = 0, inh = 0, pf = 0, up = 1, aen = 1;
    logic [2:0] blk = 3'h0;
    logic [3:0] slow = 4'h0;
    logic [15:0] a = 16'h0000, d = 16'h0000, addr, wdat, dout, rdat;
    logic bhe, rd, wr, done, ack, xack, aack, oe_n, wa_n;
    logic [7:0] ucs, lcs, rba, uwr, lwr, urd, lrd, ram_u[0:2047], ram_l[0:2047], exp_b[0:4095];
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    always #12.5 clk_in = ~clk_in;
    function automatic logic [2:0] ix(input logic [7:0] s);
        for (int i = 0; i < 8; i++) if (s[i]) return i[2:0];
        return 3'h0;
    endfunction
    // ==========
    // chip arrays behind the controller
    always @(posedge clk_in) if (!wa_n) begin
        if (ucs != 0) ram_u[{ix(ucs), rba}] <= uwr;
        if (lcs != 0) ram_l[{ix(lcs), rba}] <= lwr;
    end
    assign urd = ram_u[{ix(ucs), rba}];
    assign lrd = ram_l[{ix(lcs), rba}];
    bus_master_model u_bm(.clk_in(clk_in), .go_in(go), .op_wr_in(op), .word_in(wd), .a_in(a),
        .d_in(d), .slow_in(slow), .xack_in(xack), .bus_rd_in(dout), .addr_out(addr),
        .bhe_out(bhe), .rd_out(rd), .wr_out(wr), .data_out(wdat), .done_out(done),
        .ack_out(ack), .rdata_out(rdat));
    bus_slave_static_ram_control #(.ONESHOT_LEN(3)) u_dut(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .addr_in(addr), .byte_high_en_in(bhe), .read_cmd_in(rd), .write_cmd_in(wr),
        .inhibit_in(inh), .power_fail_in(pf), .strap_upper_half_in(up), .strap_block_in(blk),
        .strap_aack_en_in(aen), .bus_data_in(wdat), .ram_upper_rd_in(urd), .ram_lower_rd_in(lrd),
        .bus_data_out(dout), .bus_data_oe_n_out(oe_n), .xack_out(xack), .aack_out(aack),
        .board_select_out(), .read_direction_n_out(), .byte_swap_enable_out(),
        .upper_chip_pair_selects_out(ucs), .lower_chip_pair_selects_out(lcs),
        .ram_byte_addr_out(rba), .ram_upper_wr_out(uwr), .ram_lower_wr_out(lwr),
        .write_strobe_a_n_out(wa_n), .write_strobe_b_n_out(), .secondary_chip_enable_out(),
        .ram_block_n_out(), .seq_slot_out());
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, s); end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic word, input logic [15:0] ad, input logic [15:0] dt);
        op <= w; wd <= word; a <= ad; d <= dt; go <= 1'b1; slow <= 4'($urandom_range(0, 5));
        @(posedge clk_in); go <= 1'b0;
        do @(posedge clk_in); while (!done);
        repeat (8) @(posedge clk_in); // clear must finish first
    endtask
    always @(posedge clk_in) if (++cyc == 60000) begin n_mismatch++; close_out(); end
    initial begin
        logic [11:0] o;
        logic [15:0] base, dt;
        logic word;
        void'($urandom(58));
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            up <= 1'($urandom); blk <= 3'($urandom); aen <= 1'($urandom);
            @(posedge clk_in);
            base = {up, blk, 12'h000};
            word = 1'($urandom);
            o = 12'($urandom) & (word ? 12'hFFE : 12'hFFF);
            dt = 16'($urandom);
            xfer(1, word, base | o, dt);
            chk("write ack", 1, ack);
            exp_b[o] = dt[7:0];
            if (word) exp_b[o | 1] = dt[15:8];
            xfer(0, word, base | o, ~dt);
            chk("read ack", 1, ack);
            chk("read data", word ? {exp_b[o | 1], exp_b[o]} : {8'h00, exp_b[o]},
                word ? rdat : {8'h00, rdat[7:0]});
        end
        xfer(0, 0, {~up, blk, 12'h010}, 0);
        chk("unselected ack", 0, ack);
        inh <= 1'b1;
        xfer(0, 0, {up, blk, 12'h010}, 0);
        chk("inhibit ack", 0, ack);
        inh <= 1'b0; pf <= 1'b1;
        xfer(1, 0, {up, blk, 12'h010}, 0);
        chk("power fail ack", 0, ack);
        pf <= 1'b0;
        close_out();
    end
endmodule // testbench
bind bus_slave_static_ram_control ram_ctrl_sva u_sva(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .addr_in(addr_in), .read_cmd_in(read_cmd_in), .write_cmd_in(write_cmd_in),
    .inhibit_in(inhibit_in), .power_fail_in(power_fail_in), .strap_aack_en_in(strap_aack_en_in),
    .strap_upper_half_in(strap_upper_half_in), .seq_slot_out(seq_slot_out),
    .bus_data_oe_n_out(bus_data_oe_n_out), .xack_out(xack_out), .aack_out(aack_out),
    .board_select_out(board_select_out), .read_direction_n_out(read_direction_n_out),
    .write_strobe_a_n_out(write_strobe_a_n_out), .write_strobe_b_n_out(write_strobe_b_n_out),
    .secondary_chip_enable_out(secondary_chip_enable_out), .ram_block_n_out(ram_block_n_out));
`default_nettype wire
